// ---- inc/vcpu_alias_pkg.sv ----
`default_nettype none

package vcpu_alias_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_LR = 4;
    localparam int LR_IDX_W = 2;
    localparam int ID_W = 10;
    localparam int CPU_W = 3;
    localparam int PRI_W = 5;
    localparam int APR_W = 32;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_GROUP1_EOI = 12'h024;
    localparam logic [ADDR_W-1:0] OFS_GROUP1_HPPI = 12'h028;
    localparam logic [ADDR_W-1:0] OFS_APR_FIRST = 12'h0D0;
    localparam logic [ADDR_W-1:0] OFS_APR_LAST = 12'h0DC;
    localparam logic [ADDR_W-1:0] OFS_NS_APR_FIRST = 12'h0E0;
    localparam logic [ADDR_W-1:0] OFS_NS_APR_LAST = 12'h0EC;

    // ----------------------------------------------------------------
    // Field layout of the aliased registers
    // ----------------------------------------------------------------
    localparam int ID_LSB = 0;
    localparam int ID_MSB = 9;
    localparam int CPU_LSB = 10;
    localparam int CPU_MSB = 12;
    localparam logic [ID_W-1:0] SPURIOUS_ID = 10'h3FF;

    // ----------------------------------------------------------------
    // List entry states, bus answers and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] LR_INVALID = 2'h0;
    localparam logic [1:0] LR_PENDING = 2'h1;
    localparam logic [1:0] LR_ACTIVE = 2'h2;
    localparam logic [1:0] LR_ACTIVE_PENDING = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [DATA_W-1:0] RESET_DATA = 32'h0000_0000;

    typedef struct packed {
        logic [ID_W-1:0] virtual_id;
        logic [ID_W-1:0] physical_id;
        logic [CPU_W-1:0] source_processor_id;
        logic [PRI_W-1:0] prio;
        logic group1;
        logic hw;
        logic [1:0] state;
    } list_entry_s;

    typedef struct packed {
        logic valid;
        logic [LR_IDX_W-1:0] index;
    } lr_deact_s;

    typedef struct packed {
        logic valid;
        logic [ID_W-1:0] physical_id;
    } dist_deact_s;

endpackage

`default_nettype wire

// ---- hdl/vcpu_alias_eoi_hppi.sv ----
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module vcpu_alias_eoi_hppi
    import vcpu_alias_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus, write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Register bus, write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Register bus, read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // State of the rest of the virtual interface
    input wire list_entry_s [NUM_LR-1:0] list_entries,
    input wire logic [APR_W-1:0] hypervisor_active_priorities,
    input wire logic split_completion_mode,
    input wire logic acknowledge_control,
    input wire logic [PRI_W-1:0] priority_mask,
    // Completion effects
    output logic [APR_W-1:0] apr_clear,
    output lr_deact_s lr_deact,
    output dist_deact_s dist_deact
);

    // ----------------------------------------------------------------
    // Write channel holding registers
    // ----------------------------------------------------------------
    logic aw_held_r, aw_held_nxt;
    logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
    logic w_held_r, w_held_nxt;
    logic [DATA_W-1:0] w_data_r, w_data_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic do_write;
    logic wr_mapped;

    // ----------------------------------------------------------------
    // Read channel registers
    // ----------------------------------------------------------------
    logic rvalid_r, rvalid_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [DATA_W-1:0] rd_value;
    logic rd_mapped;

    // ----------------------------------------------------------------
    // Completion outputs
    // ----------------------------------------------------------------
    logic [APR_W-1:0] apr_clear_r, apr_clear_nxt;
    lr_deact_s lr_deact_r, lr_deact_nxt;
    dist_deact_s dist_deact_r, dist_deact_nxt;

    // ----------------------------------------------------------------
    // Search results
    // ----------------------------------------------------------------
    logic pend_found;
    logic [LR_IDX_W-1:0] pend_idx;
    logic [PRI_W-1:0] pend_prio;
    logic [DATA_W-1:0] hppi_value;
    logic eoi_found;
    logic [LR_IDX_W-1:0] eoi_idx;
    logic [ID_W-1:0] eoi_id;
    logic [CPU_W-1:0] eoi_cpu;
    logic [APR_W-1:0] apr_top_bit;
    logic is_eoi_write;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // The low two address bits pick a byte inside a word and take no part in decoding.
    logic [ADDR_W-1:0] rd_addr;
    logic rd_is_hppi;
    logic rd_is_apr0;
    logic rd_in_apr_rest;
    logic rd_in_ns_apr;
    logic rd_is_eoi;
    logic wr_in_apr;
    logic wr_in_ns_apr;
    assign rd_addr = {araddr[ADDR_W-1:2], 2'b00};
    assign rd_is_hppi = (rd_addr == OFS_GROUP1_HPPI);
    assign rd_is_apr0 = (rd_addr == OFS_APR_FIRST);
    assign rd_in_apr_rest = (rd_addr > OFS_APR_FIRST) && (rd_addr <= OFS_APR_LAST);
    assign rd_in_ns_apr = (rd_addr >= OFS_NS_APR_FIRST) && (rd_addr <= OFS_NS_APR_LAST);
    assign rd_is_eoi = (rd_addr == OFS_GROUP1_EOI);
    assign wr_in_apr = (aw_addr_r >= OFS_APR_FIRST) && (aw_addr_r <= OFS_APR_LAST);
    assign wr_in_ns_apr = (aw_addr_r >= OFS_NS_APR_FIRST) && (aw_addr_r <= OFS_NS_APR_LAST);

    // Protection bits and acknowledge control have no effect on this block.
    logic unused_inputs;
    assign unused_inputs = ^{awprot, arprot, wstrb, acknowledge_control};

    // ----------------------------------------------------------------
    // Highest-priority pending entry
    // ----------------------------------------------------------------
    // Only plain pending entries compete; active-and-pending ones stay hidden. Ties go
    // to the lower entry index so that the answer is stable.
    always_comb begin
        pend_found = 1'b0;
        pend_idx = '0;
        pend_prio = '1;
        for (int i = 0; i < NUM_LR; i++) begin
            if (list_entries[i].state == LR_PENDING) begin
                if (!pend_found || (list_entries[i].prio < pend_prio)) begin
                    pend_found = 1'b1;
                    pend_idx = LR_IDX_W'(i);
                    pend_prio = list_entries[i].prio;
                end
            end
        end
    end

    always_comb begin
        hppi_value = RESET_DATA;
        hppi_value[ID_MSB:ID_LSB] = SPURIOUS_ID;
        if (pend_found && (pend_prio < priority_mask) && list_entries[pend_idx].group1) begin
            hppi_value[ID_MSB:ID_LSB] = list_entries[pend_idx].virtual_id;
            if (!list_entries[pend_idx].hw) begin
                hppi_value[CPU_MSB:CPU_LSB] = list_entries[pend_idx].source_processor_id;
            end
        end
    end

    // ----------------------------------------------------------------
    // Matching active entry for a completion
    // ----------------------------------------------------------------
    assign eoi_id = w_data_r[ID_MSB:ID_LSB];
    assign eoi_cpu = w_data_r[CPU_MSB:CPU_LSB];

    always_comb begin
        eoi_found = 1'b0;
        eoi_idx = '0;
        for (int i = 0; i < NUM_LR; i++) begin
            if (!eoi_found
                && ((list_entries[i].state == LR_ACTIVE)
                    || (list_entries[i].state == LR_ACTIVE_PENDING))
                && (list_entries[i].virtual_id == eoi_id)
                && (list_entries[i].hw || (list_entries[i].source_processor_id == eoi_cpu))) begin
                eoi_found = 1'b1;
                eoi_idx = LR_IDX_W'(i);
            end
        end
    end

    // Bit 0 is the highest priority level, so the lowest set bit is the one to drop.
    always_comb begin
        apr_top_bit = '0;
        for (int i = APR_W - 1; i >= 0; i--) begin
            if (hypervisor_active_priorities[i]) begin
                apr_top_bit = '0;
                apr_top_bit[i] = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    // Address and data are taken in either order and held until both are in; the
    // response is withheld until the previous one has been accepted.
    assign awready = !aw_held_r && !bvalid_r;
    assign wready = !w_held_r && !bvalid_r;
    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign is_eoi_write = do_write && (aw_addr_r == OFS_GROUP1_EOI);

    // Active-priority writes are accepted and dropped, which keeps read-then-write-back
    // free of side effects.
    assign wr_mapped = (aw_addr_r == OFS_GROUP1_EOI)
        || wr_in_apr
        || wr_in_ns_apr;

    always_comb begin
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt = w_held_r;
        w_data_nxt = w_data_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (awvalid && awready) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = {awaddr[ADDR_W-1:2], 2'b00};
        end
        if (wvalid && wready) begin
            w_held_nxt = 1'b1;
            w_data_nxt = wdata;
        end
        if (do_write) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_held_r <= 1'b0;
            w_data_r <= RESET_DATA;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r <= w_held_nxt;
            w_data_r <= w_data_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    assign bvalid = bvalid_r;
    assign bresp = bresp_r;

    // ----------------------------------------------------------------
    // Completion effects
    // ----------------------------------------------------------------
    // A write that matches no active entry still drops the running priority; the
    // completion count kept elsewhere in the unit covers that case.
    always_comb begin
        apr_clear_nxt = '0;
        lr_deact_nxt = '0;
        dist_deact_nxt = '0;
        if (is_eoi_write) begin
            apr_clear_nxt = apr_top_bit;
            if (!split_completion_mode && eoi_found) begin
                lr_deact_nxt.valid = 1'b1;
                lr_deact_nxt.index = eoi_idx;
                if (list_entries[eoi_idx].hw && list_entries[eoi_idx].group1) begin
                    dist_deact_nxt.valid = 1'b1;
                    dist_deact_nxt.physical_id = list_entries[eoi_idx].physical_id;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            apr_clear_r <= '0;
            lr_deact_r <= '0;
            dist_deact_r <= '0;
        end else begin
            apr_clear_r <= apr_clear_nxt;
            lr_deact_r <= lr_deact_nxt;
            dist_deact_r <= dist_deact_nxt;
        end
    end

    assign apr_clear = apr_clear_r;
    assign lr_deact = lr_deact_r;
    assign dist_deact = dist_deact_r;

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    // The first active-priorities word mirrors the hypervisor copy; the rest of the
    // set and the whole non-secure set read as zero.
    always_comb begin
        rd_value = RESET_DATA;
        rd_mapped = 1'b1;
        if (rd_is_hppi) begin
            rd_value = hppi_value;
        end else if (rd_is_apr0) begin
            rd_value = hypervisor_active_priorities;
        end else if (rd_in_apr_rest) begin
            rd_value = RESET_DATA;
        end else if (rd_in_ns_apr) begin
            rd_value = RESET_DATA;
        end else if (rd_is_eoi) begin
            rd_value = RESET_DATA;
        end else begin
            rd_mapped = 1'b0;
        end
    end

    assign arready = !rvalid_r;

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (arvalid && arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_value;
            rresp_nxt = rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= RESET_DATA;
            rresp_r <= RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

endmodule

`default_nettype wire

// ---- test/vcpu_alias_eoi_hppi_properties.sv ----
`timescale 1ns/1ns
`default_nettype none

module vcpu_alias_checker
    import vcpu_alias_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    // Interface state and completion effects
    input wire list_entry_s [NUM_LR-1:0] list_entries,
    input wire logic [APR_W-1:0] hypervisor_active_priorities,
    input wire logic split_completion_mode,
    input wire logic [APR_W-1:0] apr_clear,
    input wire lr_deact_s lr_deact,
    input wire dist_deact_s dist_deact
);
    // ----------------------------------------------------------------
    // Helper state
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] wa_r;
    logic [ADDR_W-1:0] ra_r;
    logic ap_hit;
    list_entry_s hit_e;
    always_ff @(posedge aclk) begin
        if (awvalid && awready) begin
            wa_r <= awaddr;
        end
        if (arvalid && arready) begin
            ra_r <= araddr;
        end
    end
    // Entries are held steady by software while a read is answered, so no history is needed.
    always_comb begin
        ap_hit = 1'b0;
        for (int i = 0; i < NUM_LR; i++) begin
            if (list_entries[i].state == LR_ACTIVE_PENDING &&
                list_entries[i].virtual_id == rdata[ID_MSB:ID_LSB]) begin
                ap_hit = 1'b1;
            end
        end
    end
    assign hit_e = list_entries[lr_deact.index];
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_apr_cause;
        apr_clear != '0 |-> $rose(bvalid) && wa_r == OFS_GROUP1_EOI && bresp == RESP_OKAY;
    endproperty
    a_apr_cause: assert property (p_apr_cause) else $error("apr clear without completion");
    property p_apr_lowest;
        $rose(bvalid) && wa_r == OFS_GROUP1_EOI |->
            apr_clear == ($past(hypervisor_active_priorities) & -$past(hypervisor_active_priorities));
    endproperty
    a_apr_lowest: assert property (p_apr_lowest) else $error("wrong apr bit cleared");
    property p_lr_mode;
        lr_deact.valid |-> $rose(bvalid) && !$past(split_completion_mode) && hit_e.state[1];
    endproperty
    a_lr_mode: assert property (p_lr_mode) else $error("bad list deactivation");
    property p_dist_lr;
        dist_deact.valid |-> lr_deact.valid && hit_e.hw && !$past(split_completion_mode);
    endproperty
    a_dist_lr: assert property (p_dist_lr) else $error("distributor request unmatched");
    property p_dist_group1;
        dist_deact.valid |-> hit_e.group1 && dist_deact.physical_id == hit_e.physical_id;
    endproperty
    a_dist_group1: assert property (p_dist_group1) else $error("bad distributor request");
    property p_rd_answer;
        arvalid && arready |=> rvalid && !arready;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_hppi_not_ap;
        rvalid && ra_r == OFS_GROUP1_HPPI |-> !ap_hit && rdata[DATA_W-1:CPU_MSB+1] == '0;
    endproperty
    a_hppi_not_ap: assert property (p_hppi_not_ap) else $error("pending read shows active");
    property p_ns_raz;
        rvalid && ra_r >= OFS_NS_APR_FIRST && ra_r <= OFS_NS_APR_LAST |->
            rdata == '0 && rresp == RESP_OKAY;
    endproperty
    a_ns_raz: assert property (p_ns_raz) else $error("second priority set not zero");
endmodule

bind vcpu_alias_eoi_hppi vcpu_alias_checker vcpu_alias_checker_inst (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .bresp, .bvalid, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .list_entries, .hypervisor_active_priorities,
    .split_completion_mode, .apr_clear, .lr_deact, .dist_deact
);

`default_nettype wire

// ---- test/vcpu_alias_eoi_hppi_bench.sv ----
`timescale 1ns/1ns
`default_nettype none

module vcpu_alias_eoi_hppi_bench
    import vcpu_alias_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [DATA_W-1:0] wdata = '0;
    logic split_completion_mode = 1'b0, acknowledge_control = 1'b0;
    logic [PRI_W-1:0] priority_mask = 5'h1F;
    logic [APR_W-1:0] hypervisor_active_priorities = '0;
    list_entry_s [NUM_LR-1:0] list_entries = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [DATA_W-1:0] rdata;
    logic [APR_W-1:0] apr_clear, apr_seen;
    lr_deact_s lr_deact, lr_seen;
    dist_deact_s dist_deact, dist_seen;
    int n_mismatch = 0, cmp_count = 0, cycles = 0;
    // Completion table: {acknowledge control, mode}, written word, expected effects.
    logic [1:0] eoi_cfg [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
    logic [DATA_W-1:0] eoi_dat [6] = '{32'h040, 32'h1442, 32'h1042, 32'h040, 32'h043, 32'h043};
    logic [2:0] eoi_lr [6] = '{3'h4, 3'h5, 3'h0, 3'h0, 3'h6, 3'h0};
    logic [10:0] eoi_dist [6] = '{11'h6C0, 11'h000, 11'h000, 11'h000, 11'h555, 11'h000};

    vcpu_alias_eoi_hppi vcpu_alias_eoi_hppi_inst (
        .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .list_entries, .hypervisor_active_priorities,
        .split_completion_mode, .acknowledge_control, .priority_mask, .apr_clear, .lr_deact,
        .dist_deact
    );

    initial forever #50 aclk = ~aclk;

    // ----------------------------------------------------------------
    // Pulse capture and hang guard
    // ----------------------------------------------------------------
    // Pulses last one cycle only, so they are latched here and judged after the write.
    // The latches clear when a write address is taken, which never meets a pulse.
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (awvalid === 1'b1 && awready === 1'b1) {apr_seen, lr_seen, dist_seen} <= '0;
        if (apr_clear !== '0) apr_seen <= apr_clear;
        if (lr_deact.valid === 1'b1) lr_seen <= lr_deact;
        if (dist_deact.valid === 1'b1) dist_seen <= dist_deact;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            final_report();
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] exp, input logic [31:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] er);
        logic aw_p, w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        while (aw_p || w_p) begin
            @(posedge aclk);
            if (aw_p && awready === 1'b1) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready === 1'b1) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge aclk);
    endtask

    task automatic rd(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ed,
            input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        check(n, ed, rdata);
        check("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        list_entries[0] <= '{10'h05A, 10'h000, 3'h3, 5'h08, 1'b1, 1'b0, LR_PENDING};
        list_entries[1] <= '{10'h123, 10'h011, 3'h6, 5'h04, 1'b1, 1'b1, LR_PENDING};
        list_entries[2] <= '{10'h077, 10'h000, 3'h1, 5'h01, 1'b1, 1'b0, LR_ACTIVE_PENDING};
        for (int k = 0; k < 2; k++) begin
            acknowledge_control <= k[0];
            rd("hppi_hw", OFS_GROUP1_HPPI, 32'h0000_0123, RESP_OKAY);
        end
        list_entries[1].prio <= 5'h0A;
        rd("hppi_sw", OFS_GROUP1_HPPI, 32'h0000_0C5A, RESP_OKAY);
        list_entries[0].group1 <= 1'b0;
        rd("hppi_grp0", OFS_GROUP1_HPPI, 32'h0000_03FF, RESP_OKAY);
        list_entries[0].group1 <= 1'b1;
        priority_mask <= 5'h08;
        rd("hppi_mask", OFS_GROUP1_HPPI, 32'h0000_03FF, RESP_OKAY);
        priority_mask <= 5'h09;
        rd("hppi_edge", OFS_GROUP1_HPPI, 32'h0000_0C5A, RESP_OKAY);
        hypervisor_active_priorities <= 32'h0000_0014;
        rd("apr0", OFS_APR_FIRST, 32'h0000_0014, RESP_OKAY);
        wr(OFS_APR_FIRST, 32'h0000_0014, RESP_OKAY);
        check("apr_kept", 32'h0, apr_seen);
        rd("apr0_again", OFS_APR_FIRST, 32'h0000_0014, RESP_OKAY);
        wr(OFS_NS_APR_FIRST, 32'hFFFF_FFFF, RESP_OKAY);
        rd("ns_apr0", OFS_NS_APR_FIRST, 32'h0, RESP_OKAY);
        rd("ns_apr3", OFS_NS_APR_LAST, 32'h0, RESP_OKAY);
        rd("eoi_read", OFS_GROUP1_EOI, 32'h0, RESP_OKAY);
        rd("unmapped", 12'h100, 32'h0, RESP_SLVERR);
        wr(OFS_GROUP1_HPPI, 32'h0000_0123, RESP_SLVERR);
        check("hppi_write", 32'h0, apr_seen);
        list_entries[0] <= '{10'h040, 10'h2C0, 3'h0, 5'h02, 1'b1, 1'b1, LR_ACTIVE};
        list_entries[1] <= '{10'h042, 10'h000, 3'h5, 5'h03, 1'b1, 1'b0, LR_ACTIVE};
        list_entries[2] <= '{10'h043, 10'h155, 3'h0, 5'h03, 1'b1, 1'b1, LR_ACTIVE_PENDING};
        for (int k = 0; k < 6; k++) begin
            {acknowledge_control, split_completion_mode} <= eoi_cfg[k];
            wr(OFS_GROUP1_EOI, eoi_dat[k], RESP_OKAY);
            check("apr_clear", 32'h0000_0004, apr_seen);
            check("lr_deact", {29'h0, eoi_lr[k]}, {29'h0, lr_seen});
            check("dist_deact", {21'h0, eoi_dist[k]}, {21'h0, dist_seen});
        end
        final_report();
    end
endmodule

`default_nettype wire
